// ### design/dips_pkg.sv
// Purpose: Constants for the DMA global interrupt, pacing, trigger and checksum block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: Register offsets are byte addresses within the DMA space
package dips_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] DIPS_OFF_RAW_STATUS = 12'h400;
   localparam logic [11:0] DIPS_OFF_IRQ0_ENABLE = 12'h404;
   localparam logic [11:0] DIPS_OFF_IRQ0_FORCE = 12'h408;
   localparam logic [11:0] DIPS_OFF_IRQ0_STATUS = 12'h40C;
   localparam logic [11:0] DIPS_OFF_IRQ1_ENABLE = 12'h414;
   localparam logic [11:0] DIPS_OFF_IRQ1_FORCE = 12'h418;
   localparam logic [11:0] DIPS_OFF_IRQ1_STATUS = 12'h41C;
   localparam logic [11:0] DIPS_OFF_TIMER_A = 12'h420;
   localparam logic [11:0] DIPS_OFF_TIMER_B = 12'h424;
   localparam logic [11:0] DIPS_OFF_GROUP_TRIG = 12'h430;
   localparam logic [11:0] DIPS_OFF_MON_CTRL = 12'h434;
   localparam logic [11:0] DIPS_OFF_MON_DATA = 12'h438;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int DIPS_CTRL_EN_BIT = 0;
   localparam int DIPS_CTRL_CH_LSB = 1;
   localparam int DIPS_CTRL_ALG_LSB = 5;
   localparam int DIPS_CTRL_BYTE_REV_BIT = 9;
   localparam int DIPS_CTRL_RESULT_BIT_REVERSE_BIT = 10;
   localparam int DIPS_CTRL_RESULT_INVERT_BIT = 11;
   localparam logic [31:0] DIPS_CTRL_MASK = 32'h0000_0FFF;
   localparam logic [31:0] DIPS_REG_RESET = 32'h0000_0000;
   // ****************************************
   // Algorithm codes and polynomials
   // ****************************************
   localparam logic [3:0] DIPS_ALG_CRC32 = 4'h0;
   localparam logic [3:0] DIPS_ALG_CRC32_REV = 4'h1;
   localparam logic [3:0] DIPS_ALG_CRC16 = 4'h2;
   localparam logic [3:0] DIPS_ALG_CRC16_REV = 4'h3;
   localparam logic [3:0] DIPS_ALG_XOR = 4'hE;
   localparam logic [3:0] DIPS_ALG_SUM = 4'hF;
   localparam logic [31:0] DIPS_POLY_CRC32 = 32'h04C1_1DB7;
   localparam logic [15:0] DIPS_POLY_CRC16 = 16'h1021;
   // ****************************************
   // Pace source codes
   // ****************************************
   localparam logic [5:0] DIPS_PACE_TIMER_A = 6'h3B;
   localparam logic [5:0] DIPS_PACE_TIMER_B = 6'h3C;
   localparam logic [5:0] DIPS_PACE_ALWAYS = 6'h3F;
endpackage

// ### design/dips_top.sv
// Purpose: Global DMA logic: IRQ routing, X/Y pacing timers, group trigger, checksum monitor
// Assumes: Channel engines outside; inputs synchronous to i_clk_sys
// Notes: Avalon-MM slave answers every access in the cycle after it is presented
module dips_top #(
   parameter int NCH = 16
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [11:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Channel events and state
   input wire logic [NCH-1:0] i_chan_irq_set,
   input wire logic [NCH-1:0] i_chan_enabled,
   input wire logic [NCH-1:0] i_chan_busy,
   output logic [NCH-1:0] o_chan_trigger,
   // Pacing
   input wire logic [NCH*6-1:0] i_pace_source_select,
   input wire logic [NCH-1:0] i_dreq,
   output logic [NCH-1:0] o_pace_request,
   output logic [1:0] o_timer_tick,
   // Read data seen by the monitor, already after channel byte swap
   input wire logic i_rd_valid,
   input wire logic [3:0] i_rd_chan,
   input wire logic [31:0] i_rd_data,
   // Interrupt lines
   output logic [1:0] o_irq
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [15:0] raw;
      logic [15:0] en0;
      logic [15:0] frc0;
      logic [15:0] en1;
      logic [15:0] frc1;
      logic [31:0] tmr_a;
      logic [31:0] tmr_b;
      logic [15:0] acc_a;
      logic [15:0] acc_b;
      logic [1:0] tick;
      logic [15:0] trig;
      logic [11:0] ctrl;
      logic [31:0] data;
      logic ack;
      logic [31:0] rdata;
   } dips_state_t;

   dips_state_t st_reg;
   dips_state_t st_next;

   function automatic logic [31:0] dips_rev32(input logic [31:0] v);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = v[31-i];
      end
      return r;
   endfunction

   function automatic logic [31:0] dips_input_byte_reverse(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   function automatic logic [31:0] dips_crc32(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = (r[31] ^ d[i]) ? ((r << 1) ^ dips_pkg::DIPS_POLY_CRC32) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic [15:0] dips_crc16(input logic [15:0] c, input logic [31:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = (r[15] ^ d[i]) ? ((r << 1) ^ dips_pkg::DIPS_POLY_CRC16) : (r << 1);
      end
      return r;
   endfunction

   // X/Y fractional step: add X each cycle, wrap by Y, request on wrap
   function automatic logic [16:0] dips_pace(input logic [31:0] t, input logic [15:0] a);
      logic [16:0] s;
      logic [15:0] x;
      logic [15:0] y;
      x = t[31:16];
      y = t[15:0];
      s = {1'b0, a} + {1'b0, x};
      if (x == 16'h0000 || y == 16'h0000) begin
         return {1'b0, a};
      end
      if (s >= {1'b0, y}) begin
         s = s - {1'b0, y};
         return {1'b1, s[15:0]};
      end
      return {1'b0, s[15:0]};
   endfunction

   logic [15:0] raw_or_frc0;
   logic [15:0] raw_or_frc1;
   logic [15:0] sts0;
   logic [15:0] sts1;
   logic acc_hit;
   logic bus_req;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] feed;
   logic [31:0] result_view;
   logic [16:0] pa;
   logic [16:0] pb;

   // ****************************************
   // Combinational next state
   // ****************************************
   always_comb begin
      st_next = st_reg;
      raw_or_frc0 = st_reg.raw | st_reg.frc0;
      raw_or_frc1 = st_reg.raw | st_reg.frc1;
      sts0 = raw_or_frc0 & st_reg.en0;
      sts1 = raw_or_frc1 & st_reg.en1;
      bus_req = (i_avs_read | i_avs_write) & ~st_reg.ack;
      wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
               {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
      wval = i_avs_writedata & wmask;
      result_view = st_reg.data;
      if (st_reg.ctrl[dips_pkg::DIPS_CTRL_RESULT_BIT_REVERSE_BIT]) begin
         result_view = dips_rev32(result_view);
      end
      if (st_reg.ctrl[dips_pkg::DIPS_CTRL_RESULT_INVERT_BIT]) begin
         result_view = ~result_view;
      end
      // Incoming data already carries the channel swap; a second swap restores order
      feed = i_rd_data;
      if (st_reg.ctrl[dips_pkg::DIPS_CTRL_BYTE_REV_BIT]) begin
         feed = dips_input_byte_reverse(feed);
      end
      acc_hit = st_reg.ctrl[dips_pkg::DIPS_CTRL_EN_BIT] & i_rd_valid
         & (i_rd_chan == st_reg.ctrl[dips_pkg::DIPS_CTRL_CH_LSB +: 4]);

      // Pacing timers
      pa = dips_pace(st_reg.tmr_a, st_reg.acc_a);
      pb = dips_pace(st_reg.tmr_b, st_reg.acc_b);
      st_next.acc_a = pa[15:0];
      st_next.acc_b = pb[15:0];
      st_next.tick = {pb[16], pa[16]};
      st_next.trig = '0;
      st_next.ack = bus_req;
      st_next.rdata = '0;

      // Bus writes
      if (bus_req && i_avs_write) begin
         unique case (i_avs_address)
            dips_pkg::DIPS_OFF_RAW_STATUS: st_next.raw = st_reg.raw & ~wval[15:0];
            dips_pkg::DIPS_OFF_IRQ0_STATUS: st_next.raw = st_reg.raw & ~wval[15:0];
            dips_pkg::DIPS_OFF_IRQ1_STATUS: st_next.raw = st_reg.raw & ~wval[15:0];
            dips_pkg::DIPS_OFF_IRQ0_ENABLE: begin
               st_next.en0 = (st_reg.en0 & ~wmask[15:0]) | wval[15:0];
            end
            dips_pkg::DIPS_OFF_IRQ0_FORCE: begin
               st_next.frc0 = (st_reg.frc0 & ~wmask[15:0]) | wval[15:0];
            end
            dips_pkg::DIPS_OFF_IRQ1_ENABLE: begin
               st_next.en1 = (st_reg.en1 & ~wmask[15:0]) | wval[15:0];
            end
            dips_pkg::DIPS_OFF_IRQ1_FORCE: begin
               st_next.frc1 = (st_reg.frc1 & ~wmask[15:0]) | wval[15:0];
            end
            dips_pkg::DIPS_OFF_TIMER_A: begin
               st_next.tmr_a = (st_reg.tmr_a & ~wmask) | wval;
               st_next.acc_a = '0;
            end
            dips_pkg::DIPS_OFF_TIMER_B: begin
               st_next.tmr_b = (st_reg.tmr_b & ~wmask) | wval;
               st_next.acc_b = '0;
            end
            dips_pkg::DIPS_OFF_GROUP_TRIG: begin
               st_next.trig = wval[15:0] & i_chan_enabled & ~i_chan_busy;
            end
            dips_pkg::DIPS_OFF_MON_CTRL: begin
               st_next.ctrl = ((st_reg.ctrl & ~wmask[11:0]) | wval[11:0])
                  & dips_pkg::DIPS_CTRL_MASK[11:0];
            end
            dips_pkg::DIPS_OFF_MON_DATA: begin
               st_next.data = (st_reg.data & ~wmask) | wval;
            end
            default: begin
            end
         endcase
      end

      // Bus reads; unmapped addresses read zero
      if (bus_req && i_avs_read) begin
         unique case (i_avs_address)
            dips_pkg::DIPS_OFF_RAW_STATUS: st_next.rdata = {16'h0000, st_reg.raw};
            dips_pkg::DIPS_OFF_IRQ0_ENABLE: st_next.rdata = {16'h0000, st_reg.en0};
            dips_pkg::DIPS_OFF_IRQ0_FORCE: st_next.rdata = {16'h0000, st_reg.frc0};
            dips_pkg::DIPS_OFF_IRQ0_STATUS: st_next.rdata = {16'h0000, sts0};
            dips_pkg::DIPS_OFF_IRQ1_ENABLE: st_next.rdata = {16'h0000, st_reg.en1};
            dips_pkg::DIPS_OFF_IRQ1_FORCE: st_next.rdata = {16'h0000, st_reg.frc1};
            dips_pkg::DIPS_OFF_IRQ1_STATUS: st_next.rdata = {16'h0000, sts1};
            dips_pkg::DIPS_OFF_TIMER_A: st_next.rdata = st_reg.tmr_a;
            dips_pkg::DIPS_OFF_TIMER_B: st_next.rdata = st_reg.tmr_b;
            dips_pkg::DIPS_OFF_MON_CTRL: st_next.rdata = {20'h00000, st_reg.ctrl};
            dips_pkg::DIPS_OFF_MON_DATA: st_next.rdata = result_view;
            default: st_next.rdata = '0;
         endcase
      end

      // Checksum update; a bus seed write in the same cycle loses to hardware
      if (acc_hit) begin
         unique case (st_reg.ctrl[dips_pkg::DIPS_CTRL_ALG_LSB +: 4])
            dips_pkg::DIPS_ALG_CRC32: st_next.data = dips_crc32(st_reg.data, feed);
            dips_pkg::DIPS_ALG_CRC32_REV: begin
               st_next.data = dips_crc32(st_reg.data, dips_rev32(feed));
            end
            dips_pkg::DIPS_ALG_CRC16: begin
               st_next.data = {16'h0000, dips_crc16(st_reg.data[15:0], feed)};
            end
            dips_pkg::DIPS_ALG_CRC16_REV: begin
               st_next.data = {16'h0000,
                  dips_crc16(st_reg.data[15:0], dips_rev32(feed))};
            end
            dips_pkg::DIPS_ALG_XOR: begin
               st_next.data = {31'h00000000, st_reg.data[0] ^ (^feed)};
            end
            dips_pkg::DIPS_ALG_SUM: st_next.data = st_reg.data + feed;
            default: st_next.data = st_reg.data;
         endcase
      end

      // New channel events win over a same-cycle clear
      st_next.raw = st_next.raw | i_chan_irq_set[15:0];
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_reg.ack;
      o_avs_readdata = st_reg.rdata;
      o_irq = {|sts1, |sts0};
      o_chan_trigger = st_reg.trig;
      o_timer_tick = st_reg.tick;
      for (int n = 0; n < NCH; n++) begin
         unique case (i_pace_source_select[n*6 +: 6])
            dips_pkg::DIPS_PACE_TIMER_A: o_pace_request[n] = st_reg.tick[0];
            dips_pkg::DIPS_PACE_TIMER_B: o_pace_request[n] = st_reg.tick[1];
            dips_pkg::DIPS_PACE_ALWAYS: o_pace_request[n] = 1'b1;
            default: o_pace_request[n] = i_dreq[n];
         endcase
      end
   end
endmodule

// ### tb/dips_monitor.sv
// Purpose: Port-level assertions for dips_top
// Assumes: One clock domain, synchronous active-high reset
// Notes: Sees only top ports, so register contents are judged by the bench
module dips_monitor #(
   parameter int NCH = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [11:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [NCH-1:0] i_chan_irq_set,
   input wire logic [NCH-1:0] i_chan_enabled,
   input wire logic [NCH-1:0] i_chan_busy,
   input wire logic [NCH-1:0] o_chan_trigger,
   input wire logic [NCH*6-1:0] i_pace_source_select,
   input wire logic [NCH-1:0] o_pace_request,
   input wire logic [NCH-1:0] i_dreq,
   input wire logic [1:0] o_timer_tick,
   input wire logic [1:0] o_irq
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   AST_TRIG_IDLE: assert property (
      |o_chan_trigger |-> (o_chan_trigger & ~($past(i_chan_enabled) & ~$past(i_chan_busy))) == '0)
      else $error("trigger to a disabled or busy channel");
   AST_TRIG_CAUSE: assert property (
      |o_chan_trigger |-> $past(i_avs_write && o_avs_waitrequest
      && i_avs_address == dips_pkg::DIPS_OFF_GROUP_TRIG)) else $error("trigger without write");
   AST_TRIG_PULSE: assert property (
      |o_chan_trigger |=> o_chan_trigger == '0) else $error("trigger did not self clear");
   AST_PACE_ALWAYS: assert property (
      i_pace_source_select[5:0] == dips_pkg::DIPS_PACE_ALWAYS |-> o_pace_request[0])
      else $error("permanent pace request missing");
   AST_PACE_TIMER_A: assert property (
      i_pace_source_select[11:6] == dips_pkg::DIPS_PACE_TIMER_A
      |-> o_pace_request[1] == o_timer_tick[0]) else $error("timer a pace mismatch");
   AST_PACE_TIMER_B: assert property (
      i_pace_source_select[17:12] == dips_pkg::DIPS_PACE_TIMER_B
      |-> o_pace_request[2] == o_timer_tick[1]) else $error("timer b pace mismatch");
   AST_PACE_DREQ: assert property (
      i_pace_source_select[23:18] < dips_pkg::DIPS_PACE_TIMER_A
      |-> o_pace_request[3] == i_dreq[3]) else $error("data request not passed through");
   AST_QUIET_AFTER_RESET: assert property (
      $past(i_rst) |-> o_timer_tick == 2'b00 && o_irq == 2'b00) else $error("active after reset");
   AST_IRQ_RISE: assert property (
      (o_irq & ~$past(o_irq)) != 2'b00 |-> $past(|i_chan_irq_set || (i_avs_write
      && o_avs_waitrequest))) else $error("irq line rose without cause");
   AST_BUS_ANSWER: assert property (
      $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("read not answered after one wait cycle");
endmodule

// ### tb/dips_irq_host.sv
// Purpose: Interrupt controller stand-in for the two request lines
// Assumes: Level-sensitive lines, sampled on the system clock
// Notes: Registers what it sees, one cycle late like a real input stage
module dips_irq_host (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [1:0] i_irq,
   output logic [1:0] o_seen
);
   always_ff @(posedge i_clk_sys) begin
      o_seen <= i_rst ? 2'b00 : i_irq;
   end
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for dips_top
// Assumes: Avalon master with one wait cycle per access
// Notes: Reads queue expected data; a negedge watcher compares it
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = 16;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [11:0] i_avs_address = '0;
   logic [31:0] i_avs_writedata = '0, o_avs_readdata, i_rd_data = '0, rnd = 32'h2E455F3E, acc;
   logic [3:0] i_avs_byteenable = 4'hF, i_rd_chan = '0;
   logic [NCH-1:0] i_chan_irq_set = '0, i_chan_enabled = '0, i_chan_busy = '0, i_dreq = '0;
   logic [NCH-1:0] o_chan_trigger, o_pace_request, trig_seen = '0;
   logic [NCH*6-1:0] i_pace_source_select = '0;
   logic i_rd_valid = 1'b0, o_avs_waitrequest;
   logic [1:0] o_timer_tick, o_irq, host_seen;
   logic [31:0] exp_q[$], exp_v;
   int errors = 0, total_checks = 0, tick_a = 0, tick_b = 0;
   localparam logic [11:0] OFFS [13] = '{12'h400, 12'h404, 12'h408, 12'h40C, 12'h414, 12'h418,
      12'h41C, 12'h420, 12'h424, 12'h430, 12'h434, 12'h438, 12'h440};
   localparam logic [3:0] ALGS [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hE, 4'hF};
   always #2 i_clk_sys = ~i_clk_sys;
   dips_top #(.NCH(NCH)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_chan_irq_set(i_chan_irq_set), .i_chan_enabled(i_chan_enabled),
      .i_chan_busy(i_chan_busy), .o_chan_trigger(o_chan_trigger),
      .i_pace_source_select(i_pace_source_select), .i_dreq(i_dreq),
      .o_pace_request(o_pace_request), .o_timer_tick(o_timer_tick), .i_rd_valid(i_rd_valid),
      .i_rd_chan(i_rd_chan), .i_rd_data(i_rd_data), .o_irq(o_irq));
   dips_irq_host host_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_irq(o_irq), .o_seen(host_seen));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] brev(input logic [31:0] v);
      for (int i = 0; i < 32; i++) brev[i] = v[31-i];
   endfunction
   // Reference checksum step, msb first, data bit-reversed for codes 1 and 3, no final xor
   function automatic logic [31:0] step(input logic [3:0] a, input logic [31:0] c,
                                        input logic [31:0] d);
      logic [31:0] x;
      x = (a == 4'h1 || a == 4'h3) ? brev(d) : d;
      if (a == 4'hF) return c + d;
      if (a == 4'hE) return {31'h0, c[0] ^ (^d)};
      if (a > 4'h1) c[31:16] = 16'h0;
      for (int i = 31; i >= 0; i--) begin
         if (a < 4'h2) c = {c[30:0], 1'b0} ^ ((c[31] ^ x[i]) ? dips_pkg::DIPS_POLY_CRC32 : '0);
         else c[15:0] = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? dips_pkg::DIPS_POLY_CRC16 : '0);
      end
      return c;
   endfunction
   always @(negedge i_clk_sys) begin
      tick_a += int'(o_timer_tick[0]);
      tick_b += int'(o_timer_tick[1]);
      trig_seen = trig_seen | o_chan_trigger;
      if (i_avs_read && !o_avs_waitrequest) begin
         exp_v = exp_q.pop_front();
         `CHK("readdata", exp_v, o_avs_readdata)
      end
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= d;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while (o_avs_waitrequest === 1'b1 && n < 50);
      if (n >= 50) errors++;
      @(posedge i_clk_sys);
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic irq_is(input logic [1:0] e);
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      `CHK("irq", e, o_irq)
      `CHK("host", e, host_seen)
   endtask
   task automatic beat(input logic [3:0] ch, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_rd_valid <= 1'b1;
      i_rd_chan <= ch;
      i_rd_data <= d;
      @(posedge i_clk_sys);
      i_rd_valid <= 1'b0;
      i_rd_data <= ~d;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int i = 0; i < 13; i++) rd(OFFS[i], 32'h0);
      bus(1'b1, 12'h404, 32'h5);
      bus(1'b1, 12'h414, 32'h3);
      @(posedge i_clk_sys) i_chan_irq_set <= 16'h0005;
      @(posedge i_clk_sys) i_chan_irq_set <= 16'h0000;
      irq_is(2'b11);
      rd(12'h40C, 32'h5);
      rd(12'h41C, 32'h1);
      bus(1'b1, 12'h40C, 32'h1);
      rd(12'h400, 32'h4);
      irq_is(2'b01);
      bus(1'b1, 12'h418, 32'h8000);
      bus(1'b1, 12'h414, 32'h8003);
      rd(12'h41C, 32'h8000);
      bus(1'b1, 12'h400, 32'h4);
      rd(12'h400, 32'h0);
      irq_is(2'b10);
      bus(1'b1, 12'h408, 32'h2);
      bus(1'b1, 12'h418, 32'h0);
      irq_is(2'b00);
      bus(1'b1, 12'h404, 32'h7);
      irq_is(2'b01);
      rnd = lfsr(rnd);
      i_dreq <= rnd[15:0] | 16'h0008;
      i_pace_source_select <= {78'h0, dips_pkg::DIPS_PACE_TIMER_B, dips_pkg::DIPS_PACE_TIMER_A,
                               dips_pkg::DIPS_PACE_ALWAYS};
      bus(1'b1, 12'h420, 32'h0001_0003);
      bus(1'b1, 12'h424, 32'h0002_0000);
      rd(12'h420, 32'h0001_0003);
      repeat (4) @(posedge i_clk_sys);
      tick_a = 0;
      tick_b = 0;
      repeat (30) @(posedge i_clk_sys);
      `CHK("tick a", 10, tick_a)
      `CHK("tick b", 0, tick_b)
      `CHK("dreq pass", i_dreq[15:3], o_pace_request[15:3])
      `CHK("pace always", 1'b1, o_pace_request[0])
      bus(1'b1, 12'h424, 32'h0003_0002);
      tick_b = 0;
      repeat (30) @(posedge i_clk_sys);
      `CHK("tick b", 30, tick_b)
      rnd = lfsr(rnd);
      i_chan_enabled <= rnd[15:0];
      i_chan_busy <= rnd[31:16];
      trig_seen = '0;
      bus(1'b1, 12'h430, 32'hFFFF);
      repeat (2) @(posedge i_clk_sys);
      `CHK("trigger", rnd[15:0] & ~rnd[31:16], trig_seen)
      rd(12'h430, 32'h0);
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         acc = (ALGS[k] == 4'hE) ? 32'h0 : rnd;
         bus(1'b1, 12'h438, acc);
         bus(1'b1, 12'h434, (k > 3 ? 32'h200 : 32'h0) | {23'h0, ALGS[k], 4'h5, 1'b1});
         for (int b = 0; b < 3; b++) begin
            rnd = lfsr(rnd);
            beat(4'h5, rnd);
            beat(4'h6, ~rnd);
            acc = step(ALGS[k], acc, k > 3 ? {rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]} : rnd);
         end
         rd(12'h438, acc);
      end
      for (int m = 1; m < 4; m++) begin
         bus(1'b1, 12'h434, m << 10);
         beat(4'h5, rnd);
         rd(12'h438, m[1] ? ~(m[0] ? brev(acc) : acc) : brev(acc));
      end
      bus(1'b1, 12'h434, 32'h0);
      rd(12'h438, acc);
      close_out();
   end
endmodule
bind dips_top dips_monitor #(.NCH(NCH)) mon_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .i_chan_irq_set(i_chan_irq_set),
   .i_chan_enabled(i_chan_enabled), .i_chan_busy(i_chan_busy), .o_chan_trigger(o_chan_trigger),
   .i_pace_source_select(i_pace_source_select), .o_pace_request(o_pace_request),
   .i_dreq(i_dreq), .o_timer_tick(o_timer_tick), .o_irq(o_irq));
